// ---- ssoc_board_model.sv ----
// strap capture: board pull resistors seen at the device strap pins
// assumes the bench sets the strap pattern before every capture
`timescale 1ns/1ps
module ssoc_board_model
(
  // strap pattern, bit order of the captured vector
  input  wire logic [21:0] straps,
  // dual-purpose pin side of the device
  input  wire logic [16:0] pin_o,
  input  wire logic [16:0] pin_oe,
  output logic      [16:0] pin_i,
  // input-only strap pins
  output logic             bus_high,
  output logic             bus_low,
  output logic             xover,
  output logic             cfg_mid,
  output logic             cfg_low
);
  ////////////////////////////////////////////////////////////////////////
  // an undriven pin settles to its resistor, not to the last level
  always_comb
  begin
    for (int i = 0; i < 17; i++)
      pin_i[i] = pin_oe[i] ? pin_o[i] : straps[i];
  end
  assign bus_low  = straps[17];
  assign bus_high = straps[18];
  assign xover    = straps[19];
  assign cfg_mid  = straps[20];
  assign cfg_low  = straps[21];
endmodule : ssoc_board_model

// ---- ssoc_cap_if.sv ----
// strap capture: link between sequencer and strap store
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "ssoc_map.svh"
interface ssoc_cap_if;
  logic                        load;
  logic [`SSOC_NUM_STRAP-1:0]  pins;
  logic [`SSOC_NUM_STRAP-1:0]  straps;
  modport ctl   (output load, output pins, input straps);
  modport store (input load, input pins, output straps);
endinterface : ssoc_cap_if

// ---- ssoc_map.svh ----
// strap capture: bit positions, offsets, reset values and timing counts
// assumes the includer treats these as plain text constants
`ifndef SSOC_MAP_SVH
`define SSOC_MAP_SVH
// strap vector: dual-purpose pins first, then input-only pins
`define SSOC_NUM_DUAL     17
`define SSOC_NUM_STRAP    22
`define SSOC_I_FLOW       0
`define SSOC_I_BACKPRES   1
`define SSOC_I_COLDROP    2
`define SSOC_I_BACKOFF    3
`define SSOC_I_FRAME      4
`define SSOC_I_P4_DUPLEX  5
`define SSOC_I_P4_FLOWCTL 6
`define SSOC_I_SW_FLOWCTL 7
`define SSOC_I_INDICATOR  8
`define SSOC_I_AGING      9
`define SSOC_I_CFG_HIGH   10
`define SSOC_I_P4_AUTONEG 11
`define SSOC_I_POWER      12
`define SSOC_I_CLOCK      13
`define SSOC_I_P3_AUTONEG 14
`define SSOC_I_P3_FLOWCTL 15
`define SSOC_I_P3_DUPLEX  16
`define SSOC_I_BUS_LOW    17
`define SSOC_I_BUS_HIGH   18
`define SSOC_I_XOVER      19
`define SSOC_I_CFG_MID    20
`define SSOC_I_CFG_LOW    21
// pull levels seen with nothing fitted on the board
`define SSOC_STRAP_DEFAULT 22'h01fe00
// serial bus select codes
`define SSOC_BUS_EEPROM   2'h0
`define SSOC_BUS_MGMT     2'h1
`define SSOC_BUS_SPI      2'h2
`define SSOC_BUS_TEST     2'h3
// port control and power control fields
`define SSOC_PC_AUTONEG   7
`define SSOC_PC_DUPLEX    5
`define SSOC_PC_FLOWCTL   4
`define SSOC_PWR_HI       4
`define SSOC_PWR_LO       3
`define SSOC_PWR_NORMAL   2'h0
`define SSOC_PWR_ENERGY_DETECT_POWERDOWN     2'h1
// register byte offsets
`define SSOC_OFS_CTRL     8'h00
`define SSOC_OFS_STRAPS   8'h04
`define SSOC_OFS_STATUS   8'h08
`define SSOC_OFS_PORTS    8'h0c
`define SSOC_CTRL_RESAMPLE 0
`define SSOC_CTRL_HOSTCFG  1
// pin settle time before a warm capture
`define SSOC_CLK_NS       20
`define SSOC_SETTLE_NS    160
`define SSOC_SETTLE_CYC \
  ((`SSOC_SETTLE_NS + `SSOC_CLK_NS - 1) / `SSOC_CLK_NS)
`endif

// ---- ssoc_pkg.sv ----
// strap capture: shared types
// assumes ssoc_map.svh is on the include path
package ssoc_pkg;
  typedef enum logic {SSOC_ST_RUN, SSOC_ST_SETTLE} ssoc_state_type;
  typedef struct packed {
    logic       eeprom_master, mgmt_access, spi_slave, self_test;
    logic       use_defaults, unmanaged, auto_xover, flow_en, bp_en;
    logic       col_drop, backoff, frame1536, p4_force_fc, sw_fc_en;
    logic       ind_mode1, aging_en, p5_phy_en, xtal_clk, energy_detect_powerdown;
    logic [1:0] sw_mac_mode;
    logic [7:0] p3_ctrl, p4_ctrl, pwr_ctrl;
  } ssoc_set_type;
endpackage : ssoc_pkg

// ---- ssoc_strap_capture.sv ----
// strap capture: samples board straps at reset, decodes start settings
// assumes straps are steady while RST_B is low, wishbone classic master
`timescale 1ns/1ps
`include "ssoc_map.svh"
// Overview of operation
// - two select bits choose serial bus mode
// - select 00, no eeprom: default register values
// - low reset pin resets the control logic; the strap store loads the pins
// - sample straps as inputs in reset, drive after
// - no eeprom or cpu: unmanaged defaults
// - crossover strap high disables auto crossover
// - flow control strap low enables flow control
// - back pressure strap high enables back pressure
// - collision strap low drops excess collision frames
// - backoff strap high enables aggressive backoff
// - frame strap high allows 1536 byte frames
// - port 4 duplex fallback, low half
// - port 4 flow strap high forces flow
// - switch port flow strap high enables it
// - indicator strap selects led mode 0 or 1
// - three bit code sets port 5 interfaces
// - aging strap high enables table aging
// - port 4 autoneg strap into bit 7
// - power strap low selects energy detect
// - clock strap high selects crystal clock mode
// - port 3 autoneg strap into bit 7
// - port 3 flow bit 4, duplex bit 5
module ssoc_strap_capture
  import ssoc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  // input-only strap pins
  input  wire logic        BUS_SELECT_HIGH,
  input  wire logic        BUS_SELECT_LOW,
  input  wire logic        CROSSOVER_DISABLE_STRAP,
  input  wire logic        IFACE_CONFIG_MID,
  input  wire logic        IFACE_CONFIG_LOW,
  // dual-purpose strap pins
  input  wire logic [16:0] STRAP_PIN_I,
  output logic      [16:0] STRAP_PIN_O,
  output logic      [16:0] STRAP_PIN_OE,
  input  wire logic [16:0] FUNC_OUT,
  // configuration source
  input  wire logic        EEPROM_PRESENT,
  input  wire logic        EEPROM_DONE,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // decoded settings
  output logic             BUS_EEPROM_MASTER,
  output logic             BUS_MGMT_ACCESS,
  output logic             BUS_SPI_SLAVE,
  output logic             BUS_SELF_TEST,
  output logic             USE_DEFAULTS,
  output logic             UNMANAGED,
  output logic             AUTO_XOVER_EN,
  output logic             FLOW_CTRL_EN,
  output logic             BACK_PRESSURE_EN,
  output logic             EXCESS_COL_DROP,
  output logic             AGGR_BACKOFF_EN,
  output logic             MAX_FRAME_1536,
  output logic             P4_FORCE_FC,
  output logic             SW_PORT_FC_EN,
  output logic             INDICATOR_MODE1,
  output logic             AGING_EN,
  output logic      [1:0]  SW_MAC_MODE,
  output logic             PORT5_PHY_EN,
  output logic             XTAL_CLK_MODE,
  output logic             ENERGY_DETECT_PD,
  output logic      [7:0]  P3_CTRL,
  output logic      [7:0]  P4_CTRL,
  output logic      [7:0]  PWR_CTRL,
  output logic             CFG_BUSY
);
  ////////////////////////////////////////////////////////////////////////
  function automatic ssoc_set_type decode(
    input logic [`SSOC_NUM_STRAP-1:0] s,
    input logic                       eep_present,
    input logic                       eep_done,
    input logic                       host_cfg
  );
    ssoc_set_type r;
    logic [1:0]   sel;
    logic [2:0]   cfg;
    r   = '0;
    sel = {s[`SSOC_I_BUS_HIGH], s[`SSOC_I_BUS_LOW]};
    cfg = {s[`SSOC_I_CFG_HIGH], s[`SSOC_I_CFG_MID], s[`SSOC_I_CFG_LOW]};
    r.eeprom_master = (sel == `SSOC_BUS_EEPROM);
    r.mgmt_access   = (sel == `SSOC_BUS_MGMT);
    r.spi_slave     = (sel == `SSOC_BUS_SPI);
    r.self_test     = (sel == `SSOC_BUS_TEST);
    r.use_defaults  = r.eeprom_master && !eep_present;
    r.unmanaged     = !eep_done && !host_cfg;
    r.auto_xover    = !s[`SSOC_I_XOVER];
    r.flow_en       = !s[`SSOC_I_FLOW];
    r.bp_en         = s[`SSOC_I_BACKPRES];
    r.col_drop      = !s[`SSOC_I_COLDROP];
    r.backoff       = s[`SSOC_I_BACKOFF];
    r.frame1536     = s[`SSOC_I_FRAME];
    r.p4_force_fc   = s[`SSOC_I_P4_FLOWCTL];
    r.sw_fc_en      = s[`SSOC_I_SW_FLOWCTL];
    r.ind_mode1     = s[`SSOC_I_INDICATOR];
    r.aging_en      = s[`SSOC_I_AGING];
    // codes 000 and 100 both leave port 5 dark
    r.sw_mac_mode   = cfg[1:0];
    r.p5_phy_en     = cfg[2] && (cfg[1:0] != 2'h0);
    r.xtal_clk      = s[`SSOC_I_CLOCK];
    r.energy_detect_powerdown          = !s[`SSOC_I_POWER];
    r.pwr_ctrl[`SSOC_PWR_HI:`SSOC_PWR_LO] =
      s[`SSOC_I_POWER] ? `SSOC_PWR_NORMAL : `SSOC_PWR_ENERGY_DETECT_POWERDOWN;
    r.p4_ctrl[`SSOC_PC_AUTONEG] = s[`SSOC_I_P4_AUTONEG];
    r.p4_ctrl[`SSOC_PC_DUPLEX]  = s[`SSOC_I_P4_DUPLEX];
    r.p3_ctrl[`SSOC_PC_AUTONEG] = s[`SSOC_I_P3_AUTONEG];
    r.p3_ctrl[`SSOC_PC_FLOWCTL] = s[`SSOC_I_P3_FLOWCTL];
    r.p3_ctrl[`SSOC_PC_DUPLEX]  = s[`SSOC_I_P3_DUPLEX];
    return r;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////
  ssoc_cap_if cap ();

  ssoc_strap_store u_store (
    .clk (REF_CLK),
    .ce  (CE),
    .cap (cap.store)
  );

  ssoc_state_type state_reg;
  ssoc_state_type state_next;
  logic [3:0]     cnt_reg;
  logic [3:0]     cnt_next;
  logic           resample;
  logic           last_cnt;

  assign last_cnt = (cnt_reg == 4'(`SSOC_SETTLE_CYC - 1));
  assign cap.pins = {IFACE_CONFIG_LOW, IFACE_CONFIG_MID,
                     CROSSOVER_DISABLE_STRAP, BUS_SELECT_HIGH,
                     BUS_SELECT_LOW, STRAP_PIN_I};
  // captures all through reset; warm capture waits for the pulls to settle
  assign cap.load = !RST_B ||
                    (state_reg == SSOC_ST_SETTLE && last_cnt);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      SSOC_ST_RUN:
      begin
        if (resample)
        begin
          state_next = SSOC_ST_SETTLE;
          cnt_next   = 4'h0;
        end
      end
      SSOC_ST_SETTLE:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (last_cnt)
        begin
          state_next = SSOC_ST_RUN;
        end
      end
      default:
      begin
        state_next = SSOC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (CE)
    begin
      if (!RST_B)
      begin
        state_reg <= SSOC_ST_RUN;
        cnt_reg   <= 4'h0;
      end
      else
      begin
        state_reg <= state_next;
        cnt_reg   <= cnt_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins float to their pulls in reset and during a warm capture
  logic        drive_reg;
  logic        drive_next;
  logic [16:0] pin_o_reg;
  logic [16:0] pin_o_next;

  always_comb
  begin
    drive_next = (state_next == SSOC_ST_RUN);
    pin_o_next = FUNC_OUT;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (CE)
    begin
      if (!RST_B)
      begin
        drive_reg <= 1'b0;
        pin_o_reg <= 17'h00000;
      end
      else
      begin
        drive_reg <= drive_next;
        pin_o_reg <= pin_o_next;
      end
    end
  end

  assign STRAP_PIN_OE = {`SSOC_NUM_DUAL{drive_reg}};
  assign STRAP_PIN_O  = pin_o_reg;
  assign CFG_BUSY     = !drive_reg;

  ////////////////////////////////////////////////////////////////////////
  // wishbone: ack one cycle after the strobe, write lands on the ack edge
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        host_cfg_reg;
  logic        host_cfg_next;
  logic        wr_ctrl;
  logic        req;
  logic [31:0] status_word;
  ssoc_set_type set_reg;
  ssoc_set_type set_next;

  assign req     = WB_CYC_I && WB_STB_I;
  assign wr_ctrl = req && ack_reg && WB_WE_I && WB_SEL_I[0] &&
                   (WB_ADR_I == `SSOC_OFS_CTRL);
  // a request during a capture in flight is simply dropped
  assign resample = wr_ctrl && WB_DAT_I[`SSOC_CTRL_RESAMPLE];
  assign status_word = {10'h000, set_reg.sw_mac_mode, set_reg.p5_phy_en,
                        set_reg.xtal_clk, set_reg.energy_detect_powerdown, set_reg.aging_en,
                        set_reg.ind_mode1, set_reg.sw_fc_en,
                        set_reg.p4_force_fc, set_reg.frame1536,
                        set_reg.backoff, set_reg.col_drop, set_reg.bp_en,
                        set_reg.flow_en, set_reg.auto_xover,
                        set_reg.unmanaged, set_reg.use_defaults,
                        set_reg.self_test, set_reg.spi_slave,
                        set_reg.mgmt_access, set_reg.eeprom_master,
                        CFG_BUSY};

  always_comb
  begin
    ack_next      = req && !ack_reg;
    host_cfg_next = host_cfg_reg;
    dat_next      = 32'h00000000;
    if (wr_ctrl)
    begin
      host_cfg_next = WB_DAT_I[`SSOC_CTRL_HOSTCFG];
    end
    case (WB_ADR_I)
      `SSOC_OFS_CTRL:
      begin
        dat_next[`SSOC_CTRL_HOSTCFG] = host_cfg_reg;
      end
      `SSOC_OFS_STRAPS:
      begin
        dat_next[`SSOC_NUM_STRAP-1:0] = cap.straps;
      end
      `SSOC_OFS_STATUS:
      begin
        dat_next = status_word;
      end
      `SSOC_OFS_PORTS:
      begin
        dat_next[23:0] = {set_reg.pwr_ctrl, set_reg.p4_ctrl,
                          set_reg.p3_ctrl};
      end
      default:
      begin
        dat_next = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (CE)
    begin
      if (!RST_B)
      begin
        ack_reg      <= 1'b0;
        dat_reg      <= 32'h00000000;
        host_cfg_reg <= 1'b0;
      end
      else
      begin
        ack_reg      <= ack_next;
        dat_reg      <= dat_next;
        host_cfg_reg <= host_cfg_next;
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  ////////////////////////////////////////////////////////////////////////
  // settings follow the held straps; reset shows the pull defaults
  always_comb
  begin
    set_next = decode(cap.straps, EEPROM_PRESENT, EEPROM_DONE,
                      host_cfg_reg);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (CE)
    begin
      if (!RST_B)
      begin
        set_reg <= decode(`SSOC_STRAP_DEFAULT, 1'b0, 1'b0, 1'b0);
      end
      else
      begin
        set_reg <= set_next;
      end
    end
  end

  assign BUS_EEPROM_MASTER = set_reg.eeprom_master;
  assign BUS_MGMT_ACCESS   = set_reg.mgmt_access;
  assign BUS_SPI_SLAVE     = set_reg.spi_slave;
  assign BUS_SELF_TEST     = set_reg.self_test;
  assign USE_DEFAULTS      = set_reg.use_defaults;
  assign UNMANAGED         = set_reg.unmanaged;
  assign AUTO_XOVER_EN     = set_reg.auto_xover;
  assign FLOW_CTRL_EN      = set_reg.flow_en;
  assign BACK_PRESSURE_EN  = set_reg.bp_en;
  assign EXCESS_COL_DROP   = set_reg.col_drop;
  assign AGGR_BACKOFF_EN   = set_reg.backoff;
  assign MAX_FRAME_1536    = set_reg.frame1536;
  assign P4_FORCE_FC       = set_reg.p4_force_fc;
  assign SW_PORT_FC_EN     = set_reg.sw_fc_en;
  assign INDICATOR_MODE1   = set_reg.ind_mode1;
  assign AGING_EN          = set_reg.aging_en;
  assign SW_MAC_MODE       = set_reg.sw_mac_mode;
  assign PORT5_PHY_EN      = set_reg.p5_phy_en;
  assign XTAL_CLK_MODE     = set_reg.xtal_clk;
  assign ENERGY_DETECT_PD  = set_reg.energy_detect_powerdown;
  assign P3_CTRL           = set_reg.p3_ctrl;
  assign P4_CTRL           = set_reg.p4_ctrl;
  assign PWR_CTRL          = set_reg.pwr_ctrl;

  ////////////////////////////////////////////////////////////////////////
  // helper: true when the last edge was a live, non-reset update
  logic live_reg;

  always_ff @(posedge REF_CLK)
  begin
    live_reg <= CE && RST_B;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  pins_float_a: assert property ($rose(RST_B) |-> STRAP_PIN_OE == '0)
    else $error("strap pins driven at reset release");
  capture_hold_a: assert property (
    $rose(RST_B) && $past(CE) |-> cap.straps == $past(cap.pins))
    else $error("straps not caught during reset");
  reset_default_a: assert property (
    $rose(RST_B) && $past(CE) |-> AGING_EN && FLOW_CTRL_EN && !MAX_FRAME_1536)
    else $error("settings not at defaults after reset");
  bus_decode_a: assert property (live_reg |->
    BUS_SPI_SLAVE == ($past(cap.straps[`SSOC_I_BUS_HIGH]) &&
                      !$past(cap.straps[`SSOC_I_BUS_LOW])))
    else $error("bus select decode wrong");
  no_eeprom_a: assert property (live_reg && $past(!EEPROM_PRESENT) &&
    $past(cap.straps[`SSOC_I_BUS_HIGH:`SSOC_I_BUS_LOW]) == 2'h0
    |-> USE_DEFAULTS)
    else $error("defaults not selected without eeprom");
  unmanaged_a: assert property (live_reg |->
    UNMANAGED == !($past(EEPROM_DONE) || $past(host_cfg_reg)))
    else $error("unmanaged flag wrong");
  xover_a: assert property (live_reg |->
    AUTO_XOVER_EN != $past(cap.straps[`SSOC_I_XOVER]))
    else $error("crossover strap sense wrong");
  frame_a: assert property (live_reg |->
    MAX_FRAME_1536 == $past(cap.straps[`SSOC_I_FRAME]))
    else $error("frame size strap wrong");
  iface_a: assert property (live_reg &&
    $past(cap.straps[`SSOC_I_CFG_MID]) == 1'b0 &&
    $past(cap.straps[`SSOC_I_CFG_LOW]) == 1'b0 |-> !PORT5_PHY_EN)
    else $error("port 5 enabled on a disable code");
  power_a: assert property (live_reg && !$past(cap.straps[`SSOC_I_POWER])
    |-> PWR_CTRL[`SSOC_PWR_HI:`SSOC_PWR_LO] == `SSOC_PWR_ENERGY_DETECT_POWERDOWN &&
    ENERGY_DETECT_PD)
    else $error("energy detect field wrong");
  port3_a: assert property (live_reg |->
    P3_CTRL[`SSOC_PC_DUPLEX:`SSOC_PC_FLOWCTL] ==
    $past(cap.straps[`SSOC_I_P3_DUPLEX:`SSOC_I_P3_FLOWCTL]))
    else $error("port 3 control bits wrong");
  warm_a: assert property (resample && CE && state_reg == SSOC_ST_RUN
    |=> CE [*8] |-> !STRAP_PIN_OE[0])
    else $error("pins driven during warm capture");
endmodule : ssoc_strap_capture

// ---- ssoc_strap_capture_tb.sv ----
// strap capture: self-checking bench, reset and warm strap captures
// assumes ssoc_board_model stands in for the board resistors
`timescale 1ns/1ps
module ssoc_strap_capture_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [16:0] func = 17'h0;
  logic        eep_p = 1'b0, eep_d = 1'b0, host = 1'b0;
  logic [21:0] straps = 22'h01fe00;
  logic [16:0] pin_i, pin_o, pin_oe;
  logic        bh, bl, xo, cm, cl, ack;
  logic [31:0] rdat, outs;
  logic        bem, bma, bss, bst, ud, um, ax, fc, bp, cd, ab, mf;
  logic        p4f, swf, im, ag, pe, xm, ed, busy;
  logic [1:0]  mm;
  logic [7:0]  p3, p4, pw;
  int          n_fail = 0, samples_checked = 0;
  // lfsr seed 21165
  logic [15:0] rnd = 16'h52ad;
  logic [31:0] exp_q[$];

  always #10 clk = ~clk;
  assign outs = {10'h0, mm, pe, xm, ed, ag, im, swf, p4f, mf, ab, cd, bp,
                 fc, ax, um, ud, bst, bss, bma, bem, busy};

  ////////////////////////////////////////////////////////////////////////
  ssoc_board_model ssoc_board_model_inst (.straps(straps), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_i(pin_i), .bus_high(bh), .bus_low(bl),
    .xover(xo), .cfg_mid(cm), .cfg_low(cl));

  ssoc_strap_capture ssoc_strap_capture_inst (.REF_CLK(clk), .RST_B(rst_b),
    .CE(1'b1), .BUS_SELECT_HIGH(bh), .BUS_SELECT_LOW(bl),
    .CROSSOVER_DISABLE_STRAP(xo), .IFACE_CONFIG_MID(cm),
    .IFACE_CONFIG_LOW(cl), .STRAP_PIN_I(pin_i), .STRAP_PIN_O(pin_o),
    .STRAP_PIN_OE(pin_oe), .FUNC_OUT(func), .EEPROM_PRESENT(eep_p),
    .EEPROM_DONE(eep_d), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .BUS_EEPROM_MASTER(bem), .BUS_MGMT_ACCESS(bma),
    .BUS_SPI_SLAVE(bss), .BUS_SELF_TEST(bst), .USE_DEFAULTS(ud),
    .UNMANAGED(um), .AUTO_XOVER_EN(ax), .FLOW_CTRL_EN(fc),
    .BACK_PRESSURE_EN(bp), .EXCESS_COL_DROP(cd), .AGGR_BACKOFF_EN(ab),
    .MAX_FRAME_1536(mf), .P4_FORCE_FC(p4f), .SW_PORT_FC_EN(swf),
    .INDICATOR_MODE1(im), .AGING_EN(ag), .SW_MAC_MODE(mm),
    .PORT5_PHY_EN(pe), .XTAL_CLK_MODE(xm), .ENERGY_DETECT_PD(ed),
    .P3_CTRL(p3), .P4_CTRL(p4), .PWR_CTRL(pw), .CFG_BUSY(busy));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // status layout: busy, bus one-hot, defaults, unmanaged, strap decode
  function automatic logic [31:0] stat_exp(input logic [21:0] s);
    logic [1:0] b;
    b = {s[18], s[17]};
    return {10'h0, s[20], s[21], s[10] & (s[20] | s[21]), s[13], ~s[12],
      s[9], s[8], s[7], s[6], s[4], s[3], ~s[2], s[1], ~s[0], ~s[19],
      ~eep_d & ~host, (b == 2'h0) & ~eep_p, b == 2'h3, b == 2'h2,
      b == 2'h1, b == 2'h0, 1'b0};
  endfunction : stat_exp

  function automatic logic [31:0] port_exp(input logic [21:0] s);
    return {8'h0, 4'h0, ~s[12], 3'h0, s[11], 1'b0, s[5], 5'h0,
            s[14], 1'b0, s[16], s[15], 4'h0};
  endfunction : port_exp

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      close_out();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // read data is judged by the watcher against the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0)
    begin
      if (exp_q.size() == 0)
        check("rd_note", 32'h1, 32'h0);
      else
        check("rd_data", rdat, exp_q.pop_front());
    end

  task automatic verify();
    check("settings", outs, stat_exp(straps));
    check("settings", outs, stat_exp(straps));
    check("settings", outs, stat_exp(straps));
    check("ports", {8'h0, pw, p4, p3}, port_exp(straps));
    check("pin_o", {15'h0, pin_o}, {15'h0, func});
    rd(8'h04, {10'h0, straps});
    rd(8'h08, stat_exp(straps));
    rd(8'h0c, port_exp(straps));
  endtask : verify

  // warm capture through the resample bit, or a full reset pulse
  task automatic capture(input logic warm);
    int i, n;
    n = 0;
    if (warm)
    begin
      wb(1'b1, 8'h00, {30'h0, host, 1'b1});
      for (i = 0; i < 30; i++)
      begin
        @(posedge clk);
        if (pin_oe[0] === 1'b0)
          n++;
        else if (n > 0)
          break;
      end
      check("oe_low", 32'(n), 32'h8);
    end
    else
    begin
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      check("oe_rst", {15'h0, pin_oe}, 32'h0);
      rst_b <= 1'b1;
      host = 1'b0;
    end
    repeat (3) @(posedge clk);
    check("oe_run", {15'h0, pin_oe}, 32'h1ffff);
    verify();
  endtask : capture

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [21:0] s;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    verify();
    // every bus select code twice and every interface code once
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      s[15:0] = rnd;
      rnd = lfsr(rnd);
      s[21:16] = rnd[5:0];
      s[18:17] = k[1:0];
      {s[10], s[20], s[21]} = k[2:0];
      straps <= s;
      eep_p <= rnd[6];
      eep_d <= rnd[7];
      func <= {rnd[0], s[15:0]};
      host = rnd[8];
      capture(k[0] == 1'b0);
    end
    rd(8'h10, 32'h0);
    wb(1'b1, 8'h04, 32'hffffffff);
    rd(8'h04, {10'h0, straps});
    rd(8'h00, {30'h0, host, 1'b0});
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule : ssoc_strap_capture_tb

// ---- ssoc_strap_store.sv ----
// strap capture: register holding the captured strap levels
// assumes load is only raised while the pins are inputs
`timescale 1ns/1ps
`include "ssoc_map.svh"
module ssoc_strap_store
  import ssoc_pkg::*;
(
  // clock
  input wire logic  clk,
  input wire logic  ce,
  // capture link
  ssoc_cap_if.store cap
);
  logic [`SSOC_NUM_STRAP-1:0] straps_reg;
  logic [`SSOC_NUM_STRAP-1:0] straps_next;

  always_comb
  begin
    straps_next = cap.load ? cap.pins : straps_reg;
  end

  // no reset term: under reset load is high, so it tracks the pins
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      straps_reg <= straps_next;
    end
  end

  assign cap.straps = straps_reg;
endmodule : ssoc_strap_store
